// >>> rtl/pwm_pkg.sv
// Constants, types and encodings of the dual-slope PWM timer
package pwm_pkg;

  localparam int CNT_W = 16;
  typedef logic [CNT_W-1:0] cnt_t;

  // ----------------------------------------------------------------
  // Waveform modes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_PC_8    = 4'h1;
  localparam logic [3:0] MODE_PC_9    = 4'h2;
  localparam logic [3:0] MODE_PC_10   = 4'h3;
  localparam logic [3:0] MODE_PC_CAP  = 4'ha;
  localparam logic [3:0] MODE_PC_CMPA = 4'hb;
  localparam logic [3:0] MODE_FC_CAP  = 4'h8;
  localparam logic [3:0] MODE_FC_CMPA = 4'h9;

  localparam cnt_t TOP_8   = 16'h00ff;
  localparam cnt_t TOP_9   = 16'h01ff;
  localparam cnt_t TOP_10  = 16'h03ff;
  localparam cnt_t TOP_MAX = 16'hffff;
  localparam cnt_t BOTTOM  = 16'h0000;
  localparam cnt_t ONE     = 16'h0001;

  // ----------------------------------------------------------------
  // Output actions
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_NONINV = 2'h2;
  localparam logic [1:0] ACT_INV    = 2'h3;

  // ----------------------------------------------------------------
  // Prescaler selects and terminal counts (divider minus one)
  // ----------------------------------------------------------------
  localparam int PRE_W = 10;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_1    = 3'h1;
  localparam logic [2:0] CS_8    = 3'h2;
  localparam logic [2:0] CS_64   = 3'h3;
  localparam logic [2:0] CS_256  = 3'h4;
  localparam logic [2:0] CS_1024 = 3'h5;
  localparam logic [PRE_W-1:0] PRE_END_1    = 10'h000;
  localparam logic [PRE_W-1:0] PRE_END_8    = 10'h007;
  localparam logic [PRE_W-1:0] PRE_END_64   = 10'h03f;
  localparam logic [PRE_W-1:0] PRE_END_256  = 10'h0ff;
  localparam logic [PRE_W-1:0] PRE_END_1024 = 10'h3ff;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam cnt_t              COUNT_RST = 16'h0000;
  localparam cnt_t              CMP_RST   = 16'h0000;
  localparam logic [PRE_W-1:0]  PRE_RST   = 10'h000;
  localparam logic              BIT_RST   = 1'b0;

  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_e;

endpackage : pwm_pkg

// >>> rtl/chan_if.sv
// Signals between the timer core and one compare channel
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
  import pwm_pkg::*;
  logic tick;
  logic load;
  logic wr;
  cnt_t wdata;
  cnt_t mask;
  cnt_t count;
  cnt_t top;
  dir_e dir;
  logic [1:0] action;
  logic toggle_ok;
  logic top_set;
  logic clr;
  cnt_t active;
  logic wave;
  logic flag;

  modport core (output tick, load, wr, wdata, mask, count, top, dir,
                output action, toggle_ok, top_set, clr,
                input  active, wave, flag);
  modport chan (input  tick, load, wr, wdata, mask, count, top, dir,
                input  action, toggle_ok, top_set, clr,
                output active, wave, flag);
endinterface : chan_if
`default_nettype wire

// >>> rtl/compare_channel.sv
// One buffered compare channel with waveform output and flag
`timescale 1ns/1ps
`default_nettype none
module compare_channel
  import pwm_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_b,
  chan_if.chan      ch
);

  cnt_t buf_r;
  cnt_t buf_nxt;
  cnt_t act_r;
  cnt_t act_nxt;
  logic wave_r;
  logic wave_nxt;
  logic flag_r;
  logic flag_nxt;
  logic match;
  logic inv;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    match    = ch.tick && (ch.count == act_r);
    inv      = (ch.action == ACT_INV);
    buf_nxt  = ch.wr ? (ch.wdata & ch.mask) : buf_r;
    act_nxt  = ch.load ? buf_r : act_r;
    flag_nxt = match || ch.top_set || (flag_r && !ch.clr);
    wave_nxt = wave_r;
    if (ch.tick) begin
      case (ch.action)
        ACT_NONINV, ACT_INV: begin
          // Ends forced so zero and TOP give steady levels
          if (act_r == BOTTOM) begin
            wave_nxt = inv;
          end else if (act_r == ch.top) begin
            wave_nxt = !inv;
          end else if (match) begin
            wave_nxt = (ch.dir == DIR_UP) ? inv : !inv;
          end
        end
        ACT_TOGGLE: begin
          if (match && ch.toggle_ok) begin
            wave_nxt = !wave_r;
          end
        end
        default: wave_nxt = wave_r;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      buf_r  <= CMP_RST;
      act_r  <= CMP_RST;
      wave_r <= BIT_RST;
      flag_r <= BIT_RST;
    end else begin
      buf_r  <= buf_nxt;
      act_r  <= act_nxt;
      wave_r <= wave_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign ch.active = act_r;
  assign ch.wave   = wave_r;
  assign ch.flag   = flag_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_match_raises_flag: assert property (match |=> flag_r)
    else $error("compare flag missing after match");
  a_zero_steady_low: assert property (
    ch.tick && act_r == BOTTOM && ch.action == ACT_NONINV |=> !wave_r)
    else $error("zero compare did not hold output low");
  a_toggle_on_match: assert property (
    match && ch.toggle_ok && ch.action == ACT_TOGGLE
      |=> wave_r != $past(wave_r))
    else $error("output did not toggle on match");

endmodule : compare_channel
`default_nettype wire

// >>> rtl/dual_slope_pwm_timer.sv
// Dual-slope PWM timer: prescaler, up/down counter, two channels
`timescale 1ns/1ps
`default_nettype none
module dual_slope_pwm_timer
  import pwm_pkg::*;
#(
  parameter int COUNT_W = CNT_W
)(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [2:0] clock_select,
  input  wire logic [3:0] waveform_mode_field,
  input  wire logic [1:0] output_action_a_field,
  input  wire logic [1:0] output_action_b_field,
  input  wire logic       compare_a_wr,
  input  wire cnt_t       compare_a_wdata,
  input  wire logic       compare_b_wr,
  input  wire cnt_t       compare_b_wdata,
  input  wire logic       capture_top_wr,
  input  wire cnt_t       capture_top_wdata,
  input  wire logic       pin_direction_bit_a,
  input  wire logic       pin_direction_bit_b,
  input  wire logic       overflow_clr,
  input  wire logic       compare_a_clr,
  input  wire logic       compare_b_clr,
  input  wire logic       capture_clr,
  output cnt_t            count_value,
  output cnt_t            compare_value_a,
  output cnt_t            compare_value_b,
  output cnt_t            capture_top_value,
  output logic            overflow_flag,
  output logic            compare_a_flag,
  output logic            compare_b_flag,
  output logic            capture_match_flag,
  output logic            wave_out_a,
  output logic            wave_out_b,
  output logic            pin_a_out,
  output logic            pin_a_drive,
  output logic            pin_b_out,
  output logic            pin_b_drive
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Compare and TOP paths are built for the package counter width
  if (COUNT_W != CNT_W) begin : g_bad_width
    $error("dual_slope_pwm_timer: COUNT_W must equal CNT_W");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic [PRE_W-1:0] pre_end;
  logic             tick_r;
  logic             tick_nxt;
  logic             pre_run;

  cnt_t count_r;
  cnt_t count_nxt;
  dir_e dir_r;
  dir_e dir_nxt;
  cnt_t cap_r;
  cnt_t cap_nxt;
  logic ovf_r;
  logic ovf_nxt;
  logic capf_r;
  logic capf_nxt;

  logic pin_a_r;
  logic pin_a_nxt;
  logic drv_a_r;
  logic drv_a_nxt;
  logic pin_b_r;
  logic pin_b_nxt;
  logic drv_b_r;
  logic drv_b_nxt;

  logic pc_mode;
  logic fc_mode;
  logic dual;
  logic fixed_top;
  logic top_is_cap;
  logic top_is_a;
  cnt_t top;
  logic at_top;
  logic at_bot;

  chan_if ch_a ();
  chan_if ch_b ();

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  always_comb begin
    pre_run = 1'b1;
    case (clock_select)
      CS_1:    pre_end = PRE_END_1;
      CS_8:    pre_end = PRE_END_8;
      CS_64:   pre_end = PRE_END_64;
      CS_256:  pre_end = PRE_END_256;
      CS_1024: pre_end = PRE_END_1024;
      default: begin
        pre_end = PRE_END_1;
        pre_run = 1'b0;
      end
    endcase
    // Stopped or reserved select freezes the timer
    if (!pre_run) begin
      pre_nxt  = PRE_RST;
      tick_nxt = 1'b0;
    end else if (pre_r >= pre_end) begin
      pre_nxt  = PRE_RST;
      tick_nxt = 1'b1;
    end else begin
      pre_nxt  = pre_r + 10'h001;
      tick_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pre_r  <= PRE_RST;
      tick_r <= BIT_RST;
    end else begin
      pre_r  <= pre_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode and TOP selection
  // ----------------------------------------------------------------
  always_comb begin
    pc_mode    = 1'b0;
    fc_mode    = 1'b0;
    fixed_top  = 1'b0;
    top_is_cap = 1'b0;
    top_is_a   = 1'b0;
    top        = TOP_MAX;
    case (waveform_mode_field)
      MODE_PC_8: begin
        pc_mode = 1'b1;
        fixed_top = 1'b1;
        top = TOP_8;
      end
      MODE_PC_9: begin
        pc_mode = 1'b1;
        fixed_top = 1'b1;
        top = TOP_9;
      end
      MODE_PC_10: begin
        pc_mode = 1'b1;
        fixed_top = 1'b1;
        top = TOP_10;
      end
      MODE_PC_CAP: begin
        pc_mode = 1'b1;
        top_is_cap = 1'b1;
        top = cap_r;
      end
      MODE_PC_CMPA: begin
        pc_mode = 1'b1;
        top_is_a = 1'b1;
        top = ch_a.active;
      end
      MODE_FC_CAP: begin
        fc_mode = 1'b1;
        top_is_cap = 1'b1;
        top = cap_r;
      end
      MODE_FC_CMPA: begin
        fc_mode = 1'b1;
        top_is_a = 1'b1;
        top = ch_a.active;
      end
      default: top = TOP_MAX;
    endcase
    dual   = pc_mode || fc_mode;
    at_top = tick_r && dual && (dir_r == DIR_UP) && (count_r == top);
    at_bot = tick_r && dual && (dir_r == DIR_DOWN) && (count_r == BOTTOM);
  end

  // ----------------------------------------------------------------
  // Counter, direction, capture value and flags
  // ----------------------------------------------------------------
  always_comb begin
    count_nxt = count_r;
    dir_nxt   = dir_r;
    if (tick_r && dual) begin
      if (dir_r == DIR_UP) begin
        // A TOP lowered below the count is missed; count wraps
        if (count_r == top) begin
          count_nxt = count_r - ONE;
          dir_nxt   = DIR_DOWN;
        end else begin
          count_nxt = count_r + ONE;
        end
      end else begin
        if (count_r == BOTTOM) begin
          count_nxt = ONE;
          dir_nxt   = DIR_UP;
        end else begin
          count_nxt = count_r - ONE;
        end
      end
    end
    cap_nxt  = capture_top_wr ? capture_top_wdata : cap_r;
    ovf_nxt  = at_bot || (ovf_r && !overflow_clr);
    capf_nxt = (at_top && top_is_cap)
               || (capf_r && !capture_clr);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= COUNT_RST;
      dir_r   <= DIR_UP;
      cap_r   <= CMP_RST;
      ovf_r   <= BIT_RST;
      capf_r  <= BIT_RST;
    end else begin
      count_r <= count_nxt;
      dir_r   <= dir_nxt;
      cap_r   <= cap_nxt;
      ovf_r   <= ovf_nxt;
      capf_r  <= capf_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  // Phase correct updates at TOP, frequency correct at BOTTOM
  assign ch_a.tick      = tick_r && dual;
  assign ch_a.load      = pc_mode ? at_top : at_bot;
  assign ch_a.wr        = compare_a_wr;
  assign ch_a.wdata     = compare_a_wdata;
  assign ch_a.mask      = fixed_top ? top : TOP_MAX;
  assign ch_a.count     = count_r;
  assign ch_a.top       = top;
  assign ch_a.dir       = dir_r;
  assign ch_a.action    = output_action_a_field;
  assign ch_a.toggle_ok = top_is_a;
  assign ch_a.top_set   = at_top && top_is_a;
  assign ch_a.clr       = compare_a_clr;

  assign ch_b.tick      = tick_r && dual;
  assign ch_b.load      = pc_mode ? at_top : at_bot;
  assign ch_b.wr        = compare_b_wr;
  assign ch_b.wdata     = compare_b_wdata;
  assign ch_b.mask      = fixed_top ? top : TOP_MAX;
  assign ch_b.count     = count_r;
  assign ch_b.top       = top;
  assign ch_b.dir       = dir_r;
  assign ch_b.action    = output_action_b_field;
  assign ch_b.toggle_ok = 1'b0;
  assign ch_b.top_set   = 1'b0;
  assign ch_b.clr       = compare_b_clr;

  compare_channel u_chan_a (
    .mclk  (mclk),
    .rst_b (rst_b),
    .ch    (ch_a)
  );

  compare_channel u_chan_b (
    .mclk  (mclk),
    .rst_b (rst_b),
    .ch    (ch_b)
  );

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Toggle on channel B is reserved, so B stays off the pin then
  always_comb begin
    pin_a_nxt = ch_a.wave;
    drv_a_nxt = pin_direction_bit_a
                && (output_action_a_field != ACT_OFF);
    pin_b_nxt = ch_b.wave;
    drv_b_nxt = pin_direction_bit_b
                && (output_action_b_field != ACT_OFF)
                && (output_action_b_field != ACT_TOGGLE);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_a_r <= BIT_RST;
      drv_a_r <= BIT_RST;
      pin_b_r <= BIT_RST;
      drv_b_r <= BIT_RST;
    end else begin
      pin_a_r <= pin_a_nxt;
      drv_a_r <= drv_a_nxt;
      pin_b_r <= pin_b_nxt;
      drv_b_r <= drv_b_nxt;
    end
  end

  assign count_value        = count_r;
  assign compare_value_a    = ch_a.active;
  assign compare_value_b    = ch_b.active;
  assign capture_top_value  = cap_r;
  assign overflow_flag      = ovf_r;
  assign compare_a_flag     = ch_a.flag;
  assign compare_b_flag     = ch_b.flag;
  assign capture_match_flag = capf_r;
  assign wave_out_a         = ch_a.wave;
  assign wave_out_b         = ch_b.wave;
  assign pin_a_out          = pin_a_r;
  assign pin_a_drive        = drv_a_r;
  assign pin_b_out          = pin_b_r;
  assign pin_b_drive        = drv_b_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_top_reached;
    at_top;
  endsequence
  sequence s_turned_down;
    (dir_r == DIR_DOWN) && (count_r == $past(count_r) - ONE);
  endsequence

  a_top_one_tick: assert property (s_top_reached |=> s_turned_down)
    else $error("count did not leave TOP downward after one tick");
  a_bottom_turn_up: assert property (
    at_bot |=> (count_r == ONE) && (dir_r == DIR_UP))
    else $error("count did not turn upward at BOTTOM");
  a_overflow_bottom: assert property (at_bot |=> ovf_r)
    else $error("overflow flag missing at BOTTOM");
  a_fc_load_bottom: assert property (
    fc_mode && $stable(waveform_mode_field) && !at_bot
      |=> $stable(compare_value_a))
    else $error("compare A changed away from BOTTOM");
  a_cap_flag_top: assert property (
    at_top && top_is_cap |=> capf_r)
    else $error("capture flag missing at TOP");
  a_hold_no_tick: assert property (!tick_r |=> $stable(count_r))
    else $error("counter moved without a tick");
  a_pin_gated: assert property (
    !pin_direction_bit_a |=> !pin_a_drive)
    else $error("pin A driven while direction is input");
  a_flag_sticky: assert property (
    ovf_r && !overflow_clr |=> ovf_r)
    else $error("overflow flag dropped without clear");
  a_capture_direct: assert property (
    capture_top_wr |=> cap_r == $past(capture_top_wdata))
    else $error("capture value not taken at once");

endmodule : dual_slope_pwm_timer
`default_nettype wire

// >>> tb/pin_load.sv
// Resistive load on one PWM port pin, with a pull-down
`timescale 1ns/1ps
`default_nettype none
module pin_load (
  input  wire logic pin_out,
  input  wire logic pin_drive,
  output var  logic level
);
  // Released pin must read low, never the last driven value
  always_comb level = pin_drive ? pin_out : 1'b0;
endmodule : pin_load
`default_nettype wire

// >>> tb/dual_slope_pwm_timer_bench.sv
// Self-checking bench for the dual-slope PWM timer
`timescale 1ns/1ps
`default_nettype none
module dual_slope_pwm_timer_bench
  import pwm_pkg::*;
;
  logic mclk, rst_b, compare_a_wr, compare_b_wr, capture_top_wr;
  logic pin_direction_bit_a, pin_direction_bit_b, level_a, level_b;
  logic overflow_clr, compare_a_clr, compare_b_clr, capture_clr;
  logic overflow_flag, compare_a_flag, compare_b_flag, capture_match_flag;
  logic wave_out_a, wave_out_b, pin_a_out, pin_a_drive, pin_b_out;
  logic pin_b_drive;
  logic [2:0] clock_select;
  logic [3:0] waveform_mode_field;
  logic [1:0] output_action_a_field, output_action_b_field;
  cnt_t compare_a_wdata, compare_b_wdata, capture_top_wdata, count_value;
  cnt_t compare_value_a, compare_value_b, capture_top_value, held;
  int   error_cnt, n_compared, i;

  dual_slope_pwm_timer #(.COUNT_W(16)) dut (
    .mclk, .rst_b, .clock_select, .waveform_mode_field,
    .output_action_a_field, .output_action_b_field,
    .compare_a_wr, .compare_a_wdata, .compare_b_wr, .compare_b_wdata,
    .capture_top_wr, .capture_top_wdata,
    .pin_direction_bit_a, .pin_direction_bit_b,
    .overflow_clr, .compare_a_clr, .compare_b_clr, .capture_clr,
    .count_value, .compare_value_a, .compare_value_b, .capture_top_value,
    .overflow_flag, .compare_a_flag, .compare_b_flag, .capture_match_flag,
    .wave_out_a, .wave_out_b, .pin_a_out, .pin_a_drive, .pin_b_out,
    .pin_b_drive
  );
  pin_load load_a (.pin_out(pin_a_out), .pin_drive(pin_a_drive),
                   .level(level_a));
  pin_load load_b (.pin_out(pin_b_out), .pin_drive(pin_b_drive),
                   .level(level_b));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Scenario table: one row per dual-slope mode
  // ----------------------------------------------------------------
  typedef struct {
    logic [3:0] mode;
    logic [2:0] cs;
    int         div;
    cnt_t       top;
    cnt_t       ca;
    cnt_t       cb;
    logic [1:0] act;
  } row_s;
  // Compare values at 0 and TOP exercise the steady-level ends
  // Every compare at or below TOP, register TOP at least 3
  row_s rows [7] = '{
    '{4'h1, CS_1,    1,    16'h00ff, 16'h0040, 16'h0010, ACT_NONINV},
    '{4'h2, CS_8,    8,    16'h01ff, 16'h0100, 16'h01ff, ACT_INV},
    '{4'h3, CS_1,    1,    16'h03ff, 16'h0000, 16'h0200, ACT_NONINV},
    '{4'ha, CS_64,   64,   16'h0010, 16'h0010, 16'h0005, ACT_INV},
    '{4'h8, CS_1024, 1024, 16'h0003, 16'h0001, 16'h0000, ACT_INV},
    '{4'hb, CS_1,    1,    16'h0010, 16'h0010, 16'h0008, ACT_TOGGLE},
    '{4'h9, CS_256,  256,  16'h0004, 16'h0004, 16'h0003, ACT_TOGGLE}
  };

  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] want,
                       input logic [31:0] got);
    n_compared++;
    if (got !== want) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, want, got);
    end
  endtask : check

  // Waits on the overflow flag when ovf is set, else the capture flag
  task automatic wait_hi(input bit ovf);
    int   n;
    logic f;
    f = ovf ? overflow_flag : capture_match_flag;
    for (n = 0; n < 40000 && f !== 1'b1; n++) begin
      @(negedge mclk);
      f = ovf ? overflow_flag : capture_match_flag;
    end
    if (f !== 1'b1) begin
      check("wait", 1, f);
      print_verdict();
    end
  endtask : wait_hi

  task automatic do_reset();
    rst_b = 1'b0;
    {clock_select, waveform_mode_field, output_action_a_field} = '0;
    output_action_b_field = ACT_NONINV;
    {compare_a_wr, compare_b_wr, capture_top_wr} = 3'h0;
    {compare_a_wdata, compare_b_wdata, capture_top_wdata} = '0;
    {overflow_clr, compare_a_clr, compare_b_clr, capture_clr} = 4'h0;
    pin_direction_bit_a = 1'b1;
    pin_direction_bit_b = 1'b1;
    repeat (12) @(negedge mclk);
    rst_b = 1'b1;
    @(negedge mclk);
  endtask : do_reset

  task automatic write3(input cnt_t a, input cnt_t b, input cnt_t c);
    {compare_a_wdata, compare_b_wdata, capture_top_wdata} = {a, b, c};
    {compare_a_wr, compare_b_wr, capture_top_wr} = 3'h7;
    @(negedge mclk);
    {compare_a_wr, compare_b_wr, capture_top_wr} = 3'h0;
  endtask : write3

  task automatic run_row(input row_s r, input logic dir_b);
    int   k;
    int   p;
    int   hi_a;
    int   hi_b;
    int   bad;
    cnt_t mx;
    logic pa;
    logic pb;
    do_reset();
    pin_direction_bit_b = dir_b;
    output_action_a_field = r.act;
    // Prime in capture-TOP mode so the buffered compares get loaded
    waveform_mode_field = MODE_PC_CAP;
    write3(r.ca, r.cb, r.top);
    clock_select = r.cs;
    wait_hi(1'b0);
    check("load a", r.ca, compare_value_a);
    check("load b", r.cb, compare_value_b);
    waveform_mode_field = r.mode;
    wait_hi(1'b1);
    {overflow_clr, compare_a_clr, compare_b_clr, capture_clr} = 4'hf;
    {k, hi_a, hi_b, bad, mx, pa, pb} = {128'h0, 16'h0, level_a, level_b};
    do begin
      k++;
      hi_a += int'(wave_out_a);
      hi_b += int'(wave_out_b);
      if (count_value > mx) mx = count_value;
      if (level_a !== pa || level_b !== (dir_b ? pb : 1'b0)) bad++;
      pa = wave_out_a;
      pb = wave_out_b;
      @(negedge mclk);
      {overflow_clr, compare_a_clr, compare_b_clr, capture_clr} = 4'h0;
    end while (k < 20000 && overflow_flag !== 1'b1);
    p = 2 * r.div * int'(r.top);
    check("period", p, k);
    check("top", r.top, mx);
    if (r.act == ACT_TOGGLE) check("duty a", p / 2, hi_a);
    if (r.act == ACT_INV) check("duty a", p - 2*r.ca*r.div, hi_a);
    if (r.act == ACT_NONINV) check("duty a", 2*r.ca*r.div, hi_a);
    check("duty b", 2 * r.cb * r.div, hi_b);
    check("pins", 0, bad);
    check("cmp flags", 2'h3, {compare_a_flag, compare_b_flag});
    if (r.mode inside {MODE_PC_CAP, MODE_FC_CAP})
      check("cap flag", 1, capture_match_flag);
  endtask : run_row

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    error_cnt = 0;
    n_compared = 0;
    do_reset();
    check("reset count", 0, count_value);
    check("reset outs", 0, {overflow_flag, wave_out_a, pin_a_drive,
                            compare_value_a});
    foreach (rows[i]) run_row(rows[i], i[0]);
    // Fixed TOP masks the write; capture takes effect at once
    waveform_mode_field = MODE_PC_8;
    clock_select = CS_1;
    write3(16'h0040, 16'h1234, 16'h0077);
    check("cap now", 16'h0077, capture_top_value);
    check("b held", 16'h0003, compare_value_b);
    for (i = 0; i < 600 && compare_value_b !== 16'h0034; i++)
      @(negedge mclk);
    check("mask", 16'h0034, compare_value_b);
    // Frequency correct: new compare lands together with overflow
    waveform_mode_field = MODE_FC_CAP;
    overflow_clr = 1'b1;
    write3(16'h0040, 16'h0020, 16'h0077);
    overflow_clr = 1'b0;
    for (i = 0; i < 600 && compare_value_b !== 16'h0020; i++)
      @(negedge mclk);
    check("fc load", 17'h10020, {overflow_flag, compare_value_b});
    // Input direction, reserved B toggle and action off keep pins released
    pin_direction_bit_a   = 1'b0;
    pin_direction_bit_b   = 1'b1;
    output_action_b_field = ACT_TOGGLE;
    repeat (2) @(negedge mclk);
    check("pins off", 0, {pin_a_drive, pin_b_drive, level_a, level_b});
    pin_direction_bit_a   = 1'b1;
    output_action_a_field = ACT_OFF;
    repeat (2) @(negedge mclk);
    check("a off", 0, {pin_a_drive, level_a});
    clock_select = CS_STOP;
    repeat (3) @(negedge mclk);
    held = count_value;
    repeat (50) @(negedge mclk);
    check("stopped", held, count_value);
    print_verdict();
  end
endmodule : dual_slope_pwm_timer_bench
`default_nettype wire
